/* File: shared/margin_cfg.svh */
// register offsets, field positions, reset values and timing counts of the margin block
`ifndef MARGIN_CFG_SVH
`define MARGIN_CFG_SVH
`define REG_OPERATION 8'h01
`define REG_MARGIN_UPPER 8'h25
`define REG_MARGIN_LOWER 8'h26
`define REG_BUS_FAULT 8'h78
`define REG_VERSION 8'h98
`define REG_TRIGGER 8'hd3
`define OPERATION_RESET 16'h0000
`define VERSION_VALUE 16'h2200
`define FAULT_BIT 9
`define CODE_MSB 11
`define CODE_LSB 2
`define CMD_OFF 8'h00
`define CMD_ON 8'h80
`define CMD_MARGIN_UPPER 8'ha4
`define CMD_MARGIN_LOWER 8'h94
`define I2C_BASE_ADDR 7'h48
`define BUS_TIMEOUT_NS 25000000
`define CLOCK_PERIOD_NS 8
`define STEP_TIME_NS 8000
`define STEP_CYCLES (`STEP_TIME_NS / `CLOCK_PERIOD_NS)
`define TIMEOUT_CYCLES (`BUS_TIMEOUT_NS / `CLOCK_PERIOD_NS)
`endif

/* File: shared/margin_pkg.sv */
// types of the margin block
package margin_pkg;
	typedef enum logic [2:0] {
		st_idle,
		st_addr,
		st_reg,
		st_msb,
		st_lsb,
		st_read,
		st_skip
	} i2c_state_t;
endpackage : margin_pkg

/* File: sim/i2c_host.sv */
// i2c host model: open-drain master framing register writes and reads
`timescale 1ns/1ps
`include "margin_cfg.svh"
module i2c_host (
	input wire logic mclk,
	input wire logic sda_oe,
	output logic scl,
	output logic sda
);
	logic host_low = 1'b0;
	logic scl_q = 1'b1;
	// wired-and data line with pull-up
	assign sda = !(host_low || sda_oe);
	assign scl = scl_q;
	task automatic gap();
		repeat (8) @(negedge mclk);
	endtask : gap
	// data changes only while clock low, sampled while high
	task automatic bit_io(input logic b, output logic r);
		host_low = !b;
		gap();
		scl_q = 1'b1;
		gap();
		r = sda;
		scl_q = 1'b0;
		gap();
	endtask : bit_io
	task automatic byte_io(input logic [7:0] d, input logic nak, output logic [7:0] q,
		output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
			q[i] = r;
		end
		bit_io(nak, r);
		ack = !r;
	endtask : byte_io
	task automatic start();
		host_low = 1'b0;
		gap();
		scl_q = 1'b1;
		gap();
		host_low = 1'b1;
		gap();
		scl_q = 1'b0;
		gap();
	endtask : start
	task automatic stop();
		host_low = 1'b1;
		gap();
		scl_q = 1'b1;
		gap();
		host_low = 0;
		gap();
	endtask : stop
	// register address, then msb and lsb as n allows
	task automatic xfer(input logic [6:0] dev, input logic [7:0] rg, input logic [15:0] d,
		input int n, output logic ack);
		logic [7:0] q;
		logic a;
		start();
		byte_io({dev, 1'b0}, 1'b1, q, ack);
		byte_io(rg, 1'b1, q, a);
		if (n > 0) byte_io(d[15:8], 1'b1, q, a);
		if (n > 1) byte_io(d[7:0], 1'b1, q, a);
		stop();
	endtask : xfer
	task automatic rd(input logic [6:0] dev, input logic [7:0] rg, output logic [15:0] d);
		logic [7:0] q;
		logic a;
		start();
		byte_io({dev, 1'b0}, 1'b1, q, a);
		byte_io(rg, 1'b1, q, a);
		start();
		byte_io({dev, 1'b1}, 1'b1, q, a);
		byte_io(8'hff, 1'b0, d[15:8], a);
		byte_io(8'hff, 1'b1, d[7:0], a);
		stop();
	endtask : rd
	// margin request through the trigger register: zero byte, then the request bit
	task automatic trig(input logic [6:0] dev, input logic up, output logic ack);
		xfer(dev, `REG_TRIGGER, {8'h00, up ? 8'h80 : 8'h40}, 2, ack);
	endtask : trig
endmodule : i2c_host

/* File: sim/margin_props.sv */
// port assertions of the margin register block
`timescale 1ns/1ps
module margin_props #(
	parameter int CODE_WIDTH = 10,
	parameter int STEP_CYCLES = 4
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic scl_in,
	input wire logic sda_oe,
	input wire logic pmbus_enable,
	input wire logic [CODE_WIDTH-1:0] dac_code,
	input wire logic dac_powered,
	input wire logic margin_upper_busy,
	input wire logic margin_lower_busy
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	// a live step while powered in both cycles
	sequence step_s;
		$changed(dac_code) && dac_powered && $past(dac_powered);
	endsequence
	////////////////////////////////////////////////////////////////////////////
	busy_excl_a: assert property (!(margin_upper_busy && margin_lower_busy))
		else $error("both margin busy flags high");
	reset_quiet_a: assert property (disable iff (1'b0) reset |=> dac_code == '0 && !dac_powered)
		else $error("outputs not cleared by reset");
	slew_unit_a: assert property (step_s |-> dac_code == $past(dac_code) + 1'b1
		|| dac_code == $past(dac_code) - 1'b1)
		else $error("code moved by more than one");
	slew_gap_a: assert property (step_s |=> ($stable(dac_code) || !dac_powered)[*3])
		else $error("code stepped faster than the step time");
	ack_low_a: assert property ($changed(sda_oe) |-> !scl_in)
		else $error("data line moved while clock high");
	upper_enable_a: assert property ($rose(margin_upper_busy) |-> pmbus_enable)
		else $error("margin started with command mode off");
	upper_moves_a: assert property ($rose(margin_upper_busy) && dac_powered
		|-> ##[1:12] ($changed(dac_code) || !margin_upper_busy))
		else $error("upper margin did not move the code");
	lower_moves_a: assert property ($rose(margin_lower_busy) && dac_powered
		|-> ##[1:12] ($changed(dac_code) || !margin_lower_busy))
		else $error("lower margin did not move the code");
	cover property ($rose(margin_upper_busy));
	cover property ($rose(margin_lower_busy));
	cover property ($fell(dac_powered));
endmodule : margin_props

/* File: sim/tb.sv */
// testbench of the margin register block
`timescale 1ns/1ps
`include "margin_cfg.svh"
module tb;
	import margin_pkg::*;
	logic mclk, reset, scl_in, sda_in, sda_out, sda_oe, pmbus_enable, dac_powered, ack;
	logic margin_upper_busy, margin_lower_busy;
	logic [1:0] address_select_pin;
	logic [9:0] nominal_code, dac_code;
	logic [15:0] v, up, lo;
	logic [6:0] dev;
	logic nvm_valid, nvm_power_up;
	logic [15:0] nvm_margin_upper, nvm_margin_lower;
	int err_count = 0;
	int cmp_count = 0;
	dac_margin_pmbus_regs #(.CODE_WIDTH(10), .TIMEOUT_CYCLES(2000), .STEP_CYCLES(4)) dut (
		.mclk, .reset, .scl_in, .sda_in, .sda_out, .sda_oe, .address_select_pin,
		.pmbus_enable, .nominal_code, .nvm_valid, .nvm_power_up,
		.nvm_margin_upper, .nvm_margin_lower, .dac_code, .dac_powered,
		.margin_upper_busy, .margin_lower_busy);
	i2c_host host (.mclk, .sda_oe, .scl(scl_in), .sda(sda_in));
	////////////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic op(input logic [7:0] c);
		host.xfer(dev, `REG_OPERATION, {c, 8'($urandom())}, 2, ack);
	endtask : op
	// wait for the code to arrive and the margin flags to drop
	task automatic settle(input logic [9:0] exp);
		for (int i = 0; i < 6000 && !(dac_code === exp && margin_upper_busy === 1'b0
			&& margin_lower_busy === 1'b0); i++)
			@(negedge mclk);
		check("dac_code", 16'(dac_code), 16'(exp));
	endtask : settle
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : test_done
	// clock
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	// watchdog
	initial begin
		repeat (80000) @(posedge mclk);
		err_count++;
		test_done();
	end
	// main sequence
	initial begin
		reset = 1'b1;
		pmbus_enable = 1'b1;
		nvm_valid = 1'b0;
		nvm_power_up = 1'b0;
		nvm_margin_upper = 16'h0000;
		nvm_margin_lower = 16'h0000;
		void'($urandom(32'hfc32));
		address_select_pin = 2'($urandom());
		nominal_code = 10'($urandom());
		dev = `I2C_BASE_ADDR | 7'(address_select_pin);
		repeat (4) @(negedge mclk);
		reset = 1'b0;
		repeat (4) @(negedge mclk);
		check("powered", 16'(dac_powered), 16'h0000);
		host.rd(dev, `REG_OPERATION, v);
		check("operation", v, `OPERATION_RESET);
		host.rd(dev, `REG_VERSION, v);
		check("version", v, `VERSION_VALUE);
		host.xfer(dev ^ 7'h01, `REG_OPERATION, 16'h8000, 2, ack);
		check("foreign ack", 16'(ack), 16'h0000);
		$display("test basics done");
		for (int k = 0; k < 2; k++) begin
			up = k == 0 ? 16'hf003 : 16'($urandom());
			lo = k == 0 ? 16'h0ffc : 16'($urandom());
			host.xfer(dev, `REG_MARGIN_UPPER, up, 2, ack);
			check("own ack", 16'(ack), 16'h0001);
			host.xfer(dev, `REG_MARGIN_LOWER, lo, 2, ack);
			op(`CMD_ON);
			settle(nominal_code);
			check("powered", 16'(dac_powered), 16'h0001);
			op(`CMD_MARGIN_UPPER);
			settle(up[11:2]);
			op(`CMD_MARGIN_LOWER);
			settle(lo[11:2]);
			$display("test margin pass %0d done", k);
		end
		op(`CMD_OFF);
		check("powered", 16'(dac_powered), 16'h0000);
		pmbus_enable = 1'b0;
		op(`CMD_MARGIN_UPPER);
		check("upper busy", 16'(margin_upper_busy), 16'h0000);
		pmbus_enable = 1'b1;
		host.xfer(dev, `REG_MARGIN_UPPER, 16'h1234, 1, ack);
		host.rd(dev, `REG_BUS_FAULT, v);
		check("fault set", v, 16'h0200);
		host.xfer(dev, `REG_BUS_FAULT, 16'h0000, 2, ack);
		host.rd(dev, `REG_BUS_FAULT, v);
		check("fault kept", v, 16'h0200);
		host.xfer(dev, `REG_BUS_FAULT, 16'h0200, 2, ack);
		host.rd(dev, `REG_BUS_FAULT, v);
		check("fault cleared", v, 16'h0000);
		host.trig(dev, 1'($urandom()), ack);
		check("trigger ack", 16'(ack), 16'h0001);
		host.xfer(dev, `REG_MARGIN_LOWER, 16'h0000, 0, ack);
		host.rd(dev, `REG_BUS_FAULT, v);
		check("empty write", v, 16'h0200);
		$display("test faults done");
		nvm_margin_upper = 16'($urandom());
		nvm_margin_lower = 16'($urandom());
		nvm_power_up = 1'b1;
		nvm_valid = 1'b1;
		@(negedge mclk);
		nvm_valid = 1'b0;
		@(negedge mclk);
		check("nvm power", 16'(dac_powered), 16'h0001);
		op(`CMD_MARGIN_LOWER);
		settle(nvm_margin_lower[11:2]);
		$display("test nvm done");
		test_done();
	end
endmodule : tb
bind dac_margin_pmbus_regs margin_props #(.CODE_WIDTH(CODE_WIDTH), .STEP_CYCLES(STEP_CYCLES))
	props (
	.mclk, .reset, .scl_in, .sda_oe, .pmbus_enable, .dac_code, .dac_powered,
	.margin_upper_busy, .margin_lower_busy);

/* File: src/dac_margin_pmbus_regs.sv */
// i2c target, margin registers, operation command and output slewing
`timescale 1ns/1ps
`include "margin_cfg.svh"
//
// Function
// - upper margin code held in bits 11-2, or bits 11-4 for 8-bit codes
// - lower margin code held in bits 11-2, or bits 11-4 for 8-bit codes
// - operation byte 00h off, 80h on
// - command A4h moves output to upper margin
// - command 94h moves output to lower margin
// - bus faults set the communication fault flag
// - writing one clears the fault flag
// - version register reads 22h then zero
// - operation register at 01h, reset zero
// - four target addresses chosen by select pin
// - output powered down high impedance at power-up
// - output steps toward target at slew rate
// - stored settings restored from nonvolatile memory
// - margin trigger clears when code reached
// - command mode only while enable bit set
module dac_margin_pmbus_regs
	import margin_pkg::*;
#(
	parameter int CODE_WIDTH = 10,
	parameter int TIMEOUT_CYCLES = `TIMEOUT_CYCLES,
	parameter int STEP_CYCLES = `STEP_CYCLES
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic [1:0] address_select_pin,
	input wire logic pmbus_enable,
	input wire logic [CODE_WIDTH-1:0] nominal_code,
	input wire logic nvm_valid,
	input wire logic nvm_power_up,
	input wire logic [15:0] nvm_margin_upper,
	input wire logic [15:0] nvm_margin_lower,
	output logic [CODE_WIDTH-1:0] dac_code,
	output logic dac_powered,
	output logic margin_upper_busy,
	output logic margin_lower_busy
);
	initial begin
		if (CODE_WIDTH != 10 && CODE_WIDTH != 8) $error("code width must be 8 or 10");
		if (STEP_CYCLES < 1 || TIMEOUT_CYCLES < 1) $error("counts must be positive");
	end

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisation and bus edge detection
	logic scl_s;
	logic sda_s;
	logic scl_d;
	logic sda_d;
	pin_sync #(.WIDTH(2)) u_sync (
		.mclk(mclk),
		.reset(reset),
		.pin({scl_in, sda_in}),
		.level({scl_s, sda_s})
	);
	wire scl_rise = scl_s && !scl_d;
	wire scl_fall = !scl_s && scl_d;
	wire start_cond = scl_s && scl_d && sda_d && !sda_s;
	wire stop_cond = scl_s && scl_d && !sda_d && sda_s;

	////////////////////////////////////////////////////////////////////////////////
	// registers and bus state
	i2c_state_t state;
	logic [3:0] bit_cnt;
	logic [7:0] shreg;
	logic [7:0] reg_addr;
	logic [7:0] msb_byte;
	logic [15:0] read_word;
	logic read_hi;
	logic ack_phase;
	logic have_reg;
	// ninth-clock tracking and the pairing of data bytes
	logic ack_slot;
	logic ack_due;
	logic pair_done;
	logic [15:0] operation_command;
	logic [15:0] margin_upper_code;
	logic [15:0] margin_lower_code;
	logic comm_fault_flag;
	logic [31:0] idle_cnt;
	logic [31:0] step_cnt;

	// target address offset by select pin level
	wire [6:0] my_addr = `I2C_BASE_ADDR | {5'h00, address_select_pin};
	wire byte_done = scl_rise && bit_cnt == 4'd7;
	wire [7:0] next_shreg = {shreg[6:0], sda_s};

	// read multiplexer; margin codes are write-only and read zero
	wire [15:0] read_mux = (reg_addr == `REG_OPERATION) ? operation_command :
		(reg_addr == `REG_BUS_FAULT) ? {6'h00, comm_fault_flag, 9'h000} :
		(reg_addr == `REG_VERSION) ? `VERSION_VALUE : 16'h0000;

	// full two-byte write reached
	wire write_word = state == st_lsb && byte_done;
	wire [15:0] wdata = {msb_byte, next_shreg};
	wire [15:0] code_mask = (CODE_WIDTH == 10) ? 16'h0ffc : 16'h0ff0;

	// fault causes: timeout, short write at stop, read before register write
	// the stop's own clock rise counts as one bit before the stop is seen, so a clean
	// stop leaves one bit behind; a pointer with no data pair is refused as well
	wire short_write = stop_cond && (state == st_msb || state == st_lsb)
		&& bit_cnt > 4'd1;
	wire msb_stop = stop_cond && state == st_lsb && bit_cnt <= 4'd1;
	wire zero_write = stop_cond && state == st_msb && bit_cnt <= 4'd1 && !pair_done;
	wire bus_timeout = state != st_idle && idle_cnt >= TIMEOUT_CYCLES;
	wire read_nowr = state == st_addr && byte_done && next_shreg[0] && !have_reg;
	wire fault_event = short_write || msb_stop || zero_write || bus_timeout || read_nowr;
	wire fault_clear = write_word && reg_addr == `REG_BUS_FAULT && wdata[`FAULT_BIT];

	////////////////////////////////////////////////////////////////////////////////
	// i2c target state machine
	always_ff @(posedge mclk) begin
		if (reset) begin
			state <= st_idle;
			bit_cnt <= 4'd0;
			shreg <= 8'h00;
			reg_addr <= 8'h00;
			msb_byte <= 8'h00;
			read_word <= 16'h0000;
			read_hi <= 1'b0;
			ack_phase <= 1'b0;
			ack_slot <= 1'b0;
			ack_due <= 1'b0;
			pair_done <= 1'b0;
			have_reg <= 1'b0;
			sda_out <= 1'b0;
			sda_oe <= 1'b0;
			scl_d <= 1'b1;
			sda_d <= 1'b1;
			idle_cnt <= 32'd0;
		end else begin
			scl_d <= scl_s;
			sda_d <= sda_s;
			idle_cnt <= (scl_rise || scl_fall || state == st_idle) ? 32'd0 : idle_cnt + 32'd1;
			if (start_cond) begin
				state <= st_addr;
				bit_cnt <= 4'd0;
				ack_phase <= 1'b0;
				ack_slot <= 1'b0;
				// a new frame has not yet carried a complete data pair
				pair_done <= 1'b0;
				sda_oe <= 1'b0;
			end else if (stop_cond || bus_timeout) begin
				state <= st_idle;
				sda_oe <= 1'b0;
				have_reg <= 1'b0;
			end else if (state != st_idle) begin
				if (ack_phase) begin
					// the fall after the eighth bit opens the ninth clock and the next fall
					// closes it; counting this clock as data would slip every later byte
					if (scl_fall && !ack_slot) begin
						ack_slot <= 1'b1;
						sda_oe <= ack_due;
					end else if (scl_fall) begin
						ack_phase <= 1'b0;
						ack_slot <= 1'b0;
						// release the line, or put up the first bit of the next read byte
						sda_oe <= state == st_read && !read_word[15];
						if (state == st_read) read_word <= {read_word[14:0], 1'b0};
					end else if (scl_rise && state == st_read && sda_s) begin
						// a host nack ends the read, so the line stays free for the stop
						state <= st_skip;
					end
				end else if (scl_rise) begin
					shreg <= next_shreg;
					bit_cnt <= (bit_cnt == 4'd7) ? 4'd0 : bit_cnt + 4'd1;
					if (bit_cnt == 4'd7) begin
						ack_phase <= 1'b1;
						case (state)
							st_addr: begin
								if (next_shreg[7:1] != my_addr || read_nowr) begin
									state <= st_skip;
									ack_due <= 1'b0;
								end else if (next_shreg[0]) begin
									state <= st_read;
									read_word <= read_mux;
									read_hi <= 1'b1;
									ack_due <= 1'b1;
								end else begin
									state <= st_reg;
									ack_due <= 1'b1;
								end
							end
							st_reg: begin
								reg_addr <= next_shreg;
								have_reg <= 1'b1;
								state <= st_msb;
								ack_due <= 1'b1;
							end
							st_msb: begin
								msb_byte <= next_shreg;
								state <= st_lsb;
								ack_due <= 1'b1;
							end
							st_lsb: begin
								state <= st_msb;
								pair_done <= 1'b1;
								ack_due <= 1'b1;
							end
							st_read: begin
								// the host answers read bytes, so the line is left free
								read_hi <= !read_hi;
								ack_due <= 1'b0;
							end
							default: begin
								state <= st_skip;
								ack_due <= 1'b0;
							end
						endcase
					end
				end else if (scl_fall && state == st_read) begin
					// next read bit, msb first, on each falling clock
					sda_oe <= !read_word[15];
					read_word <= {read_word[14:0], 1'b0};
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// register writes and fault flag
	always_ff @(posedge mclk) begin
		if (reset) begin
			operation_command <= `OPERATION_RESET;
			margin_upper_code <= 16'h0000;
			margin_lower_code <= 16'h0000;
			comm_fault_flag <= 1'b0;
		end else begin
			if (nvm_valid) begin
				margin_upper_code <= nvm_margin_upper & code_mask;
				margin_lower_code <= nvm_margin_lower & code_mask;
			end else if (write_word) begin
				if (reg_addr == `REG_OPERATION) operation_command <= {wdata[15:8], 8'h00};
				if (reg_addr == `REG_MARGIN_UPPER) margin_upper_code <= wdata & code_mask;
				if (reg_addr == `REG_MARGIN_LOWER) margin_lower_code <= wdata & code_mask;
			end
			// a new fault wins over a clear in the same cycle
			comm_fault_flag <= fault_event | (comm_fault_flag & !fault_clear);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// output target selection and slewing
	wire cmd_write = write_word && reg_addr == `REG_OPERATION && pmbus_enable;
	wire [7:0] cmd = wdata[15:8];
	logic [CODE_WIDTH-1:0] target;
	wire [CODE_WIDTH-1:0] upper_val = margin_upper_code[`CODE_MSB -: CODE_WIDTH];
	wire [CODE_WIDTH-1:0] lower_val = margin_lower_code[`CODE_MSB -: CODE_WIDTH];
	wire step_tick = step_cnt >= STEP_CYCLES - 1;

	always_ff @(posedge mclk) begin
		if (reset) begin
			dac_powered <= 1'b0;
			dac_code <= '0;
			target <= '0;
			margin_upper_busy <= 1'b0;
			margin_lower_busy <= 1'b0;
			step_cnt <= 32'd0;
		end else begin
			step_cnt <= step_tick ? 32'd0 : step_cnt + 32'd1;
			if (nvm_valid) dac_powered <= nvm_power_up;
			if (cmd_write) begin
				case (cmd)
					`CMD_OFF: dac_powered <= 1'b0;
					`CMD_ON: begin
						dac_powered <= 1'b1;
						target <= nominal_code;
						margin_upper_busy <= 1'b0;
						margin_lower_busy <= 1'b0;
					end
					`CMD_MARGIN_UPPER: begin
						target <= upper_val;
						margin_upper_busy <= 1'b1;
						margin_lower_busy <= 1'b0;
					end
					`CMD_MARGIN_LOWER: begin
						target <= lower_val;
						margin_lower_busy <= 1'b1;
						margin_upper_busy <= 1'b0;
					end
					default: target <= target;
				endcase
			end else begin
				// busy flags drop once the output reaches the margin
				if (margin_upper_busy && dac_code == target) margin_upper_busy <= 1'b0;
				if (margin_lower_busy && dac_code == target) margin_lower_busy <= 1'b0;
			end
			// one code per step toward the target
			if (step_tick && dac_code < target) dac_code <= dac_code + 1'b1;
			else if (step_tick && dac_code > target) dac_code <= dac_code - 1'b1;
		end
	end
endmodule : dac_margin_pmbus_regs

/* File: src/pin_sync.sv */
// three-flop pin synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 2
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic [WIDTH-1:0] pin,
	output logic [WIDTH-1:0] level
);
	logic [WIDTH-1:0] s1;
	logic [WIDTH-1:0] s2;
	logic [WIDTH-1:0] s3;
	// a change counts once stages two and three agree
	always_ff @(posedge mclk) begin
		if (reset) begin
			s1 <= '1;
			s2 <= '1;
			s3 <= '1;
			level <= '1;
		end else begin
			s1 <= pin;
			s2 <= s1;
			s3 <= s2;
			for (int i = 0; i < WIDTH; i++) begin
				if (s2[i] == s3[i]) begin
					level[i] <= s3[i];
				end
			end
		end
	end
endmodule : pin_sync
